// >>> rtl/sdram_burst_access_control.sv
// Purpose: Burst read/write command handling inside an LPDDR2-style device
// Assumes: Commands on clk_sys rising edges; falling CA half presented on ca_f at that edge
// Notes: Write strobe is its own clock domain; analog skews are not modelled
`timescale 1ns/1ps
`include "burst_map.svh"

module sdram_burst_access_control import burst_pkg::*; #(
  parameter int DQ_W = 16,
  parameter int MAX_LAT = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic [9:0] ca_r,
  input wire logic [9:0] ca_f,
  input wire logic [3:0] rl,
  input wire logic [3:0] wl,
  input wire burst_len_e bl_sel,
  output logic [DQ_W-1:0] rd_dq_rise,
  output logic [DQ_W-1:0] rd_dq_fall,
  output logic rd_dq_oe,
  output logic rd_dqs_oe,
  output logic rd_dqs_run,
  output logic rd_beat_req,
  output logic [11:0] rd_beat_col,
  input wire logic [DQ_W-1:0] rd_beat_rise,
  input wire logic [DQ_W-1:0] rd_beat_fall,
  input wire logic dqs_wr_clk,
  input wire logic [DQ_W-1:0] wr_dq,
  output logic wr_beat_valid,
  output logic [11:0] wr_beat_col,
  output logic [DQ_W-1:0] wr_beat_data,
  output logic act_seen,
  output logic [1:0] act_bank,
  output logic ap_flag,
  output logic [4:0] eff_len,
  output logic [4:0] cyc_since_cmd
);

  // Command decode
  wire is_col = ~cs_n & ca_r[`CA_BIT0] & ~ca_r[`CA_BIT1];
  wire is_rd = is_col & ca_r[`CA_BIT2];
  wire is_wr = is_col & ~ca_r[`CA_BIT2];
  wire is_bst = ~cs_n & ca_r[`CA_BIT0] & ca_r[`CA_BIT1] & ~ca_r[`CA_BIT2] & ~ca_r[`CA_BIT3];
  wire is_act = ~cs_n & ~ca_r[`CA_BIT0] & ca_r[`CA_BIT1];

  // Start column, beat 0 always even
  wire [11:0] cmd_col = {ca_f[`CA_COLF_HI:`CA_COLF_LO], ca_r[`CA_COLR_HI:`CA_COLR_LO], 1'b0};

  wire [4:0] half_len = (bl_sel == BLEN_16) ? `HALF_BL16 :
                        (bl_sel == BLEN_8) ? `HALF_BL8 : `HALF_BL4;
  wire [4:0] full_len = 5'(half_len << 1);

  // Command tracking
  cmd_e last_kind_r;
  logic [4:0] gap_r;
  logic bst_done_r;
  logic [4:0] eff_len_r;

  wire in_burst = (last_kind_r != CMD_NONE) && (gap_r < half_len);
  wire gap_even = ~gap_r[0];
  wire bst_take = is_bst & in_burst & gap_even & ~bst_done_r;
  wire cut_by_cmd = (is_rd | is_wr) & in_burst & (bl_sel != BLEN_4);
  wire [4:0] gap_len = 5'(gap_r << 1);
  wire [4:0] gap_nxt = (gap_r == `GAP_RST) ? gap_r : 5'(gap_r + 5'h01);
  wire cmd_e bst_kind = (last_kind_r == CMD_RD) ? CMD_BST_RD : CMD_BST_WR;

  cmd_e new_kind;
  assign new_kind = is_rd ? CMD_RD :
                    is_wr ? CMD_WR :
                    bst_take ? bst_kind : CMD_NONE;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      last_kind_r <= CMD_NONE;
      gap_r <= `GAP_RST;
      bst_done_r <= 1'b0;
      eff_len_r <= `EFF_LEN_RST;
    end else if (is_rd | is_wr) begin
      last_kind_r <= is_rd ? CMD_RD : CMD_WR;
      gap_r <= 5'h01;
      bst_done_r <= 1'b0;
      eff_len_r <= cut_by_cmd ? gap_len : full_len;
    end else begin
      gap_r <= gap_nxt;
      if (bst_take) begin
        bst_done_r <= 1'b1;
        eff_len_r <= gap_len;
      end
    end
  end

  assign eff_len = eff_len_r;
  assign cyc_since_cmd = gap_r;

  // Activate and auto-precharge capture
  logic act_seen_r;
  logic [1:0] act_bank_r;
  logic ap_flag_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      act_seen_r <= 1'b0;
      act_bank_r <= 2'h0;
      ap_flag_r <= 1'b0;
    end else begin
      act_seen_r <= is_act;
      if (is_act) begin
        act_bank_r <= ca_r[`CA_BA_HI:`CA_BA_LO];
      end
      if (is_rd | is_wr) begin
        ap_flag_r <= ca_f[`CA_AP_BIT];
      end
    end
  end

  assign act_seen = act_seen_r;
  assign act_bank = act_bank_r;
  assign ap_flag = ap_flag_r;

  // Latency line: every read, write and accepted burst terminate walks one stage per clock
  cmd_e kind_q [MAX_LAT];
  logic [11:0] col_q [MAX_LAT];
  logic [4:0] len_q [MAX_LAT];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < MAX_LAT; i++) begin
        kind_q[i] <= CMD_NONE;
      end
    end else begin
      kind_q[0] <= new_kind;
      for (int i = 1; i < MAX_LAT; i++) begin
        kind_q[i] <= kind_q[i-1];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    col_q[0] <= cmd_col;
    len_q[0] <= half_len;
    for (int i = 1; i < MAX_LAT; i++) begin
      col_q[i] <= col_q[i-1];
      len_q[i] <= len_q[i-1];
    end
  end

  // Read engine
  wire [3:0] rd_tap = 4'(rl - `RD_TAP_OFS);
  wire rd_load = (kind_q[rd_tap] == CMD_RD);
  wire rd_stop = (kind_q[rd_tap] == CMD_BST_RD);

  logic [4:0] rd_left_r;
  logic [11:0] rd_col_r;
  logic [DQ_W-1:0] rd_dq_rise_r;
  logic [DQ_W-1:0] rd_dq_fall_r;
  logic rd_dq_oe_r;
  logic rd_dqs_oe_r;

  wire rd_act = (rd_left_r != 5'h00);
  wire [4:0] rd_left_nxt = rd_load ? len_q[rd_tap] :
                           rd_stop ? 5'h00 :
                           rd_act ? 5'(rd_left_r - 5'h01) : 5'h00;
  wire [11:0] rd_col_nxt = rd_load ? col_q[rd_tap] : 12'(rd_col_r + `COL_STEP_CLK);
  wire rd_act_nxt = (rd_left_nxt != 5'h00);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_left_r <= 5'h00;
      rd_col_r <= 12'h000;
    end else begin
      rd_left_r <= rd_left_nxt;
      rd_col_r <= rd_col_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_dq_rise_r <= '0;
      rd_dq_fall_r <= '0;
      rd_dq_oe_r <= 1'b0;
      rd_dqs_oe_r <= 1'b0;
    end else begin
      rd_dq_rise_r <= rd_act ? rd_beat_rise : '0;
      rd_dq_fall_r <= rd_act ? rd_beat_fall : '0;
      rd_dq_oe_r <= rd_act;
      rd_dqs_oe_r <= rd_act_nxt | rd_act;
    end
  end

  assign rd_beat_req = rd_act;
  assign rd_beat_col = rd_col_r;
  assign rd_dq_rise = rd_dq_rise_r;
  assign rd_dq_fall = rd_dq_fall_r;
  assign rd_dq_oe = rd_dq_oe_r;
  assign rd_dqs_run = rd_dq_oe_r;
  assign rd_dqs_oe = rd_dqs_oe_r;

  // Write strobe domain
  logic lrst_s1;
  logic lrst_s2;
  logic beat_tgl_l;
  logic [DQ_W-1:0] beat_dat_l;

  // Link side leaves reset two strobe edges after release; the strobe must run until then

  always_ff @(posedge dqs_wr_clk) begin
    lrst_s1 <= reset;
    lrst_s2 <= lrst_s1;
  end

  always_ff @(posedge dqs_wr_clk) begin
    if (lrst_s2) begin
      beat_tgl_l <= 1'b0;
      beat_dat_l <= '0;
    end else begin
      beat_tgl_l <= ~beat_tgl_l;
      beat_dat_l <= wr_dq;
    end
  end

  // Beat event crossing into clk_sys
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      tgl_s1 <= beat_tgl_l;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  wire beat_ev = tgl_s2 ^ tgl_s3;

  // Write engine
  wire [3:0] wr_tap = 4'(wl + `WR_TAP_OFS);
  wire wr_load = (kind_q[wr_tap] == CMD_WR);
  wire wr_stop = (kind_q[wr_tap] == CMD_BST_WR);

  logic [4:0] wr_left_r;
  logic [11:0] wr_col_r;
  logic wr_valid_r;
  logic [11:0] wr_col_out_r;
  logic [DQ_W-1:0] wr_data_r;

  wire wr_take = beat_ev & (wr_left_r != 5'h00);
  wire [4:0] wr_len_beats = 5'(len_q[wr_tap] << 1);
  wire [4:0] wr_left_nxt = wr_load ? wr_len_beats :
                           wr_stop ? 5'h00 :
                           wr_take ? 5'(wr_left_r - 5'h01) : wr_left_r;
  wire [11:0] wr_col_nxt = wr_load ? col_q[wr_tap] :
                           wr_take ? 12'(wr_col_r + `COL_STEP_BEAT) : wr_col_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_left_r <= 5'h00;
      wr_col_r <= 12'h000;
    end else begin
      wr_left_r <= wr_left_nxt;
      wr_col_r <= wr_col_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_valid_r <= 1'b0;
      wr_col_out_r <= 12'h000;
      wr_data_r <= '0;
    end else begin
      wr_valid_r <= wr_take;
      if (wr_take) begin
        wr_col_out_r <= wr_col_r;
        wr_data_r <= beat_dat_l;
      end
    end
  end

  assign wr_beat_valid = wr_valid_r;
  assign wr_beat_col = wr_col_out_r;
  assign wr_beat_data = wr_data_r;

endmodule

// >>> rtl/burst_map.svh
// Purpose: Offsets, field positions and counts for the burst access block
// Assumes: Included by bare name after the package
// Notes: Definitions only
`ifndef BURST_MAP_SVH
`define BURST_MAP_SVH

// Command/address field positions, rising half
`define CA_BIT0 0
`define CA_BIT1 1
`define CA_BIT2 2
`define CA_BIT3 3
`define CA_BA_LO 7
`define CA_BA_HI 8
`define CA_COLR_LO 5
`define CA_COLR_HI 6
// Command/address field positions, falling half
`define CA_AP_BIT 0
`define CA_COLF_LO 1
`define CA_COLF_HI 9

// Half burst lengths, in clocks
`define HALF_BL4 5'h02
`define HALF_BL8 5'h04
`define HALF_BL16 5'h08

// Read tap sits two stages ahead of the read latency
`define RD_TAP_OFS 4'h2
// Write tap lags the write latency by the strobe crossing delay
`define WR_TAP_OFS 4'h2

// Column steps
`define COL_STEP_CLK 12'h002
`define COL_STEP_BEAT 12'h001

// Reset values
`define GAP_RST 5'h1f
`define EFF_LEN_RST 5'h00

`endif

// >>> rtl/burst_pkg.sv
// Purpose: Types shared by the burst access block
// Assumes: Nothing
// Notes: Numeric constants live in burst_map.svh
package burst_pkg;

  typedef enum logic [1:0] {
    BLEN_4 = 2'h0,
    BLEN_8 = 2'h1,
    BLEN_16 = 2'h2
  } burst_len_e;

  typedef enum logic [4:0] {
    CMD_NONE = 5'h01,
    CMD_RD = 5'h02,
    CMD_WR = 5'h04,
    CMD_BST_RD = 5'h08,
    CMD_BST_WR = 5'h10
  } cmd_e;

endpackage

// >>> tb/burst_checker_assertions.sv
// Purpose: Port checks for the burst access block
// Assumes: Read latency of 3 where latency is checked
// Notes: Bound to the top module
`timescale 1ns/1ps
module burst_checker import burst_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic [9:0] ca_r,
  input wire logic [9:0] ca_f,
  input wire logic [3:0] rl,
  input wire burst_len_e bl_sel,
  input wire logic rd_dq_oe,
  input wire logic rd_dqs_oe,
  input wire logic rd_dqs_run,
  input wire logic wr_beat_valid,
  input wire logic act_seen,
  input wire logic [1:0] act_bank,
  input wire logic ap_flag,
  input wire logic [4:0] eff_len
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire col_acc = !cs_n && ca_r[1:0] == 2'b01;
  wire rd_cmd = col_acc && ca_r[2];
  wire bst_cmd = !cs_n && ca_r[3:0] == 4'h3;
  run_in_oe_a: assert property (rd_dqs_run |-> rd_dqs_oe && $past(rd_dqs_oe))
    else $error("strobe runs undriven");
  preamble_a: assert property ($rose(rd_dq_oe) |-> $past(rd_dqs_oe) && rd_dqs_oe) else $error("no preamble");
  rd_lat_a: assert property (rd_cmd && rl == 4'h3 |-> ##3 rd_dqs_oe ##1 rd_dq_oe) else $error("read late");
  bl4_len_a: assert property ($rose(rd_dq_oe) && bl_sel == BLEN_4 |-> rd_dq_oe[*2])
    else $error("short read");
  act_decode_a: assert property (!cs_n && ca_r[1:0] == 2'b10 |=> act_seen && act_bank == $past(ca_r[8:7]))
    else $error("activate missed");
  ap_take_a: assert property (col_acc |=> ap_flag == $past(ca_f[0])) else $error("ap flag wrong");
  wr_pulse_a: assert property (wr_beat_valid |=> !wr_beat_valid) else $error("beat pulse too long");
  bst_stop_a: assert property (bst_cmd && $past(rd_cmd, 2) && bl_sel == BLEN_16 && rl == 4'h3
    |-> ##4 !rd_dq_oe) else $error("terminate did not stop data");
  eff_trunc_a: assert property (bst_cmd && $past(rd_cmd, 2) && bl_sel == BLEN_16 |-> ##2 eff_len == 5'h04)
    else $error("effective length wrong");
  cut_len_a: assert property (rd_cmd && $past(rd_cmd, 2) && bl_sel == BLEN_8 |=> eff_len == 5'h04)
    else $error("cut length wrong");
  cover property (rd_cmd);
  cover property (rd_cmd && $past(rd_cmd, 2) && bl_sel == BLEN_8);
  cover property (bst_cmd && $past(rd_cmd, 2));
  cover property (wr_beat_valid);
endmodule

bind sdram_burst_access_control burst_checker burst_checker_i (.clk_sys, .reset, .cs_n, .ca_r, .ca_f, .rl,
  .bl_sel, .rd_dq_oe, .rd_dqs_oe, .rd_dqs_run, .wr_beat_valid, .act_seen, .act_bank, .ap_flag, .eff_len);

// >>> tb/ctrl_model.sv
// Purpose: Far side stand-in: column data source and write strobe
// Assumes: Strobe period 32 ns
// Notes: Strobe stands low and data inverts while idle
`timescale 1ns/1ps
module ctrl_model (
  input wire logic run,
  input wire logic [11:0] rd_beat_col,
  output logic [15:0] rd_beat_rise,
  output logic [15:0] rd_beat_fall,
  output logic dqs_wr_clk,
  output logic [15:0] wr_dq
);
  logic [11:0] beat_n = 12'h000;
  assign rd_beat_rise = {4'ha, rd_beat_col};
  assign rd_beat_fall = {4'h5, rd_beat_col};
  assign wr_dq = run ? {4'hc, beat_n} : ~{4'hc, beat_n};
  initial begin
    dqs_wr_clk = 1'b0;
    #3;
    forever #16 dqs_wr_clk = run & ~dqs_wr_clk;
  end
  always @(negedge dqs_wr_clk) beat_n <= run ? beat_n + 12'h001 : 12'h000;
endmodule

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the burst access block
// Assumes: RL 3, WL 1
// Notes: Strobe runs through reset and three edges past it
`timescale 1ns/1ps
module testbench;
  import burst_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, cs_n = 1'b1, run = 1'b1;
  logic [9:0] ca_r = 10'h000, ca_f = 10'h000;
  logic [3:0] rl = 4'h3, wl = 4'h1;
  burst_len_e bl_sel = BLEN_4;
  logic [15:0] rd_dq_rise, rd_dq_fall, rd_beat_rise, rd_beat_fall, wr_dq, wr_beat_data;
  logic [11:0] rd_beat_col, wr_beat_col;
  logic rd_dq_oe, rd_dqs_oe, rd_dqs_run, rd_beat_req, dqs_wr_clk, wr_beat_valid, act_seen, ap_flag;
  logic [1:0] act_bank;
  logic [4:0] eff_len, cyc_since_cmd;
  int errors = 0, tests_run = 0, cycles = 0;
  always #5 clk_sys = ~clk_sys;
  sdram_burst_access_control sdram_burst_access_control_i (.clk_sys, .reset, .cs_n, .ca_r, .ca_f, .rl, .wl,
    .bl_sel, .rd_dq_rise, .rd_dq_fall, .rd_dq_oe, .rd_dqs_oe, .rd_dqs_run, .rd_beat_req, .rd_beat_col,
    .rd_beat_rise, .rd_beat_fall, .dqs_wr_clk, .wr_dq, .wr_beat_valid, .wr_beat_col, .wr_beat_data,
    .act_seen, .act_bank, .ap_flag, .eff_len, .cyc_since_cmd);
  ctrl_model ctrl_model_i (.run, .rd_beat_col, .rd_beat_rise, .rd_beat_fall, .dqs_wr_clk, .wr_dq);
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task issue(input logic [9:0] r, input logic [9:0] f);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    ca_r <= r;
    ca_f <= f;
    @(posedge clk_sys);
    cs_n <= 1'b1;
  endtask
  task tick;
    @(posedge clk_sys);
    #1;
  endtask
  task activate;
    issue(10'h102, 10'h000);
    #1;
    check(act_seen, 1'b1);
    check(act_bank, 2'h2);
  endtask
  task read_stream;
    logic [15:0] exp [4] = '{16'ha02a, 16'ha02c, 16'ha040, 16'ha042};
    issue(10'h025, 10'h00a);
    issue(10'h005, 10'h011);
    #1;
    check(rd_dqs_oe, 1'b1);
    check(rd_dq_oe, 1'b0);
    for (int i = 0; i < 4; i++) begin
      tick;
      check(rd_dq_rise, exp[i]);
      check(rd_dq_fall, {4'h5, exp[i][11:0]});
    end
    tick;
    check(rd_dq_oe, 1'b0);
    check(ap_flag, 1'b1);
  endtask
  task term_read;
    @(posedge clk_sys);
    bl_sel <= BLEN_16;
    issue(10'h025, 10'h00a);
    issue(10'h003, 10'h000);
    issue(10'h003, 10'h000);
    tick;
    check(rd_dq_oe, 1'b0);
    check(eff_len, 5'h04);
  endtask
  task interrupt_read;
    @(posedge clk_sys);
    bl_sel <= BLEN_8;
    issue(10'h025, 10'h00a);
    issue(10'h005, 10'h011);
    #1;
    check(eff_len, 5'h04);
    check(cyc_since_cmd, 5'h01);
    for (int i = 0; i < 6; i++) begin
      tick;
      check(rd_dq_rise, (i < 2) ? 32'ha02a + 2 * i : 32'ha03c + 2 * i);
    end
    tick;
    check(rd_dq_oe, 1'b0);
  endtask
  task write_beats;
    int n;
    n = 0;
    @(posedge clk_sys);
    bl_sel <= BLEN_4;
    issue(10'h021, 10'h00a);
    repeat (5) @(posedge clk_sys);
    fork
      begin
        run <= 1'b1;
        repeat (5) @(posedge dqs_wr_clk);
        run <= 1'b0;
      end
      repeat (80) begin
        tick;
        if (wr_beat_valid === 1'b1) begin
          check(wr_beat_col, 12'h02a + n);
          check(wr_beat_data, 16'hc000 + n);
          n++;
        end
      end
    join
    check(n, 4);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      summarize;
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    // Link side leaves reset only on strobe edges
    repeat (3) @(posedge dqs_wr_clk);
    run <= 1'b0;
    activate;
    read_stream;
    term_read;
    interrupt_read;
    write_beats;
    summarize;
  end
endmodule
